// [hdl/fpt_pkg.sv]
// Constants shared by the flash protection and timing controller
package fpt_pkg;
   // Register byte offsets
   localparam logic [11:0] OFS_FLASH_ADDR = 12'h000;
   localparam logic [11:0] OFS_FLASH_DATA = 12'h004;
   localparam logic [11:0] OFS_FLASH_CTRL = 12'h008;
   localparam logic [11:0] OFS_FAULT_RAW = 12'h00c;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
   localparam logic [11:0] OFS_FAULT_CLR = 12'h014;
   localparam logic [11:0] OFS_READ_ENABLE = 12'h130;
   localparam logic [11:0] OFS_PROG_ENABLE = 12'h134;
   localparam logic [11:0] OFS_USEC_RELOAD = 12'h140;
   // Reset and factory values
   localparam logic [31:0] RST_READ_ENABLE = 32'hbfffffff;
   localparam logic [31:0] RST_PROG_ENABLE = 32'hffffffff;
   localparam logic [7:0] RST_USEC_RELOAD = 8'h31;
   localparam logic [31:0] ERASED_WORD = 32'hffffffff;
   // Control register fields
   localparam logic [15:0] CTRL_KEY = 16'ha442;
   localparam int CTRL_KEY_LSB = 16;
   localparam int CTRL_WRITE_BIT = 0;
   localparam int CTRL_ERASE_BIT = 1;
   localparam int CTRL_MERASE_BIT = 2;
   localparam int CTRL_COMMIT_BIT = 3;
   // Debug gate field inside the read enable register
   localparam int DBG_LSB = 30;
   localparam logic [1:0] DBG_OPEN = 2'h2;
   localparam int READ_BLOCKS = 30;
   localparam logic [15:0] SPECIAL_COMMIT_ADDR = 16'h0900;
   // Array geometry: 64 KB, 1 KB pages, 2 KB protection blocks
   localparam int WORD_BITS = 14;
   localparam int FLASH_WORDS = 16384;
   localparam int PAGE_LSB = 8;
   localparam int BLOCK_LSB = 9;
   localparam logic [13:0] PAGE_LAST_WORD = 14'h00ff;
   localparam logic [13:0] ARRAY_LAST_WORD = 14'h3fff;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Fault status bit
   localparam int FAULT_BIT = 0;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_WIPE = 3'b100
   } fpt_state_type;
endpackage

// [hdl/fpt_flash_ctrl.sv]
// Flash controller: protection policy, commit, microsecond timing and array
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps

// Functional notes
// (RULE_01) Erase wipes one 1 KB page to ones
// (RULE_02) Program ANDs one 32-bit word into array
// (RULE_03) Protection granule is a 2 KB block
// (RULE_04) Two 32-bit policy registers, bit per block; read enable has bits for blocks 0-29 only, bits 31:30 hold the debug field
// (RULE_05) Program enable clear refuses program and erase
// (RULE_06) Read enable clear allows only instruction fetch
// (RULE_07) Program set, read clear: no data reads
// (RULE_08) Both set: block fully open
// (RULE_09) Refused program/erase flags fault, maskable interrupt
// (RULE_10) Protected data read returns zero, flags fault
// (RULE_11) Timing derives from cycles-per-microsecond register
// (RULE_12) Reload register resets for maximum clock
// (RULE_13) Software reloads count after frequency change
// (RULE_14) Factory policy bits all open
// (RULE_15) Policy writes act now, temporary until commit
// (RULE_16) Uncommitted clears revert at power-on reset
// (RULE_17) Debug field 0x2 enables debug port access
// (RULE_18) Committed debug clear permanent, acts next power-up
// (RULE_19) Debug disable leaves JTAG TAP untouched
// (RULE_20) Software commits execute-only with debug clear
// (RULE_21) Address bit 0 selects which register commits
// (RULE_22) Address 0x900 commits debug and read bits
// (RULE_23) Microsecond tick times all operations
module fpt_flash_ctrl #(
   parameter int PROG_US = 20,
   parameter int ERASE_US = 100,
   parameter int MERASE_US = 200,
   parameter int COMMIT_US = 50
) (
   // Clock and resets
   input wire logic I_CLOCK,
   input wire logic I_RESETN,
   input wire logic I_FACTORY_RESETN,
   // AXI4-Lite write
   input wire logic [11:0] I_AXI_AWADDR,
   input wire logic I_AXI_AWVALID,
   output logic O_AXI_AWREADY,
   input wire logic [31:0] I_AXI_WDATA,
   input wire logic [3:0] I_AXI_WSTRB,
   input wire logic I_AXI_WVALID,
   output logic O_AXI_WREADY,
   output logic [1:0] O_AXI_BRESP,
   output logic O_AXI_BVALID,
   input wire logic I_AXI_BREADY,
   // AXI4-Lite read
   input wire logic [11:0] I_AXI_ARADDR,
   input wire logic I_AXI_ARVALID,
   output logic O_AXI_ARREADY,
   output logic [31:0] O_AXI_RDATA,
   output logic [1:0] O_AXI_RRESP,
   output logic O_AXI_RVALID,
   input wire logic I_AXI_RREADY,
   // Instruction fetch port
   input wire logic I_FETCH_VALID,
   input wire logic [15:0] I_FETCH_ADDR,
   output logic [31:0] O_FETCH_DATA,
   // Data side port
   input wire logic I_DATA_VALID,
   input wire logic [15:0] I_DATA_ADDR,
   output logic [31:0] O_DATA_RDATA,
   // Status
   output logic O_DEBUG_PORT_ENABLE,
   output logic O_FLASH_BUSY,
   output logic O_FLASH_IRQ
);

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
         input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [4:0] block_of(input logic [13:0] widx);
      return widx[13:fpt_pkg::BLOCK_LSB];
   endfunction

   // Blocks above the read field have no read lock bit
   function automatic logic readable(input logic [31:0] re, input logic [13:0] widx);
      logic [4:0] b;
      b = block_of(widx);
      return (b >= 5'(fpt_pkg::READ_BLOCKS)) ? 1'b1 : re[b];
   endfunction

   // Reset synchronisers
   logic [1:0] rst_sync;
   logic [1:0] fac_sync;
   logic rst_n;
   logic fac_n;

   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_FACTORY_RESETN) begin
      if (!I_FACTORY_RESETN) begin
         fac_sync <= 2'h0;
      end else begin
         fac_sync <= {fac_sync[0], 1'b1};
      end
   end

   assign rst_n = rst_sync[1];
   assign fac_n = fac_sync[1];

   // Registers
   logic [15:0] flash_addr;
   logic [31:0] flash_data;
   logic [3:0] ctrl_pend;
   logic fault_raw;
   logic fault_mask;
   logic [31:0] read_enable;
   logic [31:0] prog_enable;
   logic [31:0] read_commit;
   logic [31:0] prog_commit;
   logic [7:0] usec_reload;
   logic load_pending;
   logic debug_enable;

   // Bus state
   logic aw_hold;
   logic w_hold;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic write_go;
   logic wr_mapped;
   logic [31:0] rd_mux;
   logic rd_mapped;

   // Sequencer
   fpt_pkg::fpt_state_type state;
   logic [15:0] us_left;
   logic [7:0] us_cnt;
   logic us_tick;
   logic [13:0] wipe_idx;
   logic [13:0] wipe_end;
   logic op_done;
   logic op_reject;
   logic data_fault;
   logic [13:0] tgt_word;

   logic [31:0] flash_mem [fpt_pkg::FLASH_WORDS];

   assign O_AXI_AWREADY = !aw_hold;
   assign O_AXI_WREADY = !w_hold;
   assign O_AXI_ARREADY = !O_AXI_RVALID;
   assign write_go = aw_hold && w_hold && !O_AXI_BVALID;
   assign tgt_word = flash_addr[15:2];
   assign O_FLASH_BUSY = (ctrl_pend != 4'h0);
   assign O_FLASH_IRQ = fault_raw && fault_mask; // [RULE_09]
   // Debug gate only drives the access enable; the TAP never sees it
   assign O_DEBUG_PORT_ENABLE = debug_enable; // [RULE_19]

   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         O_AXI_BVALID <= 1'b0;
         O_AXI_BRESP <= fpt_pkg::RESP_OKAY;
      end else begin
         if (I_AXI_AWVALID && !aw_hold) begin
            aw_hold <= 1'b1;
            aw_addr <= I_AXI_AWADDR;
         end
         if (I_AXI_WVALID && !w_hold) begin
            w_hold <= 1'b1;
            w_data <= I_AXI_WDATA;
            w_strb <= I_AXI_WSTRB;
         end
         if (write_go) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            O_AXI_BVALID <= 1'b1;
            O_AXI_BRESP <= wr_mapped ? fpt_pkg::RESP_OKAY : fpt_pkg::RESP_SLVERR;
         end else if (O_AXI_BVALID && I_AXI_BREADY) begin
            O_AXI_BVALID <= 1'b0;
         end
      end
   end

   always_comb begin
      case (aw_addr[11:2])
         fpt_pkg::OFS_FLASH_ADDR[11:2],
         fpt_pkg::OFS_FLASH_DATA[11:2],
         fpt_pkg::OFS_FLASH_CTRL[11:2],
         fpt_pkg::OFS_FAULT_RAW[11:2],
         fpt_pkg::OFS_IRQ_MASK[11:2],
         fpt_pkg::OFS_FAULT_CLR[11:2],
         fpt_pkg::OFS_READ_ENABLE[11:2],
         fpt_pkg::OFS_PROG_ENABLE[11:2],
         fpt_pkg::OFS_USEC_RELOAD[11:2]: wr_mapped = 1'b1;
         default: wr_mapped = 1'b0;
      endcase
   end

   // Plain control registers; address and data locked while busy
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         flash_addr <= 16'h0000;
         flash_data <= 32'h00000000;
         fault_mask <= 1'b0;
         usec_reload <= fpt_pkg::RST_USEC_RELOAD; // [RULE_12]
      end else if (write_go) begin
         case (aw_addr[11:2])
            fpt_pkg::OFS_FLASH_ADDR[11:2]: begin
               if (!O_FLASH_BUSY) begin
                  flash_addr <= 16'(merge_bytes({16'h0000, flash_addr}, w_data, w_strb));
               end
            end
            fpt_pkg::OFS_FLASH_DATA[11:2]: begin
               if (!O_FLASH_BUSY) begin
                  flash_data <= merge_bytes(flash_data, w_data, w_strb);
               end
            end
            fpt_pkg::OFS_IRQ_MASK[11:2]: begin
               if (w_strb[0]) begin
                  fault_mask <= w_data[fpt_pkg::FAULT_BIT];
               end
            end
            fpt_pkg::OFS_USEC_RELOAD[11:2]: begin
               usec_reload <= 8'(merge_bytes({24'h000000, usec_reload}, w_data, w_strb));
            end
            default: begin
            end
         endcase
      end
   end

   // Operation start bits: keyed write, one at a time, self-clearing
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_pend <= 4'h0;
      end else if (op_done || op_reject) begin
         ctrl_pend <= 4'h0;
      end else if (write_go && aw_addr[11:2] == fpt_pkg::OFS_FLASH_CTRL[11:2] &&
            w_strb == 4'hf && !O_FLASH_BUSY &&
            w_data[31:fpt_pkg::CTRL_KEY_LSB] == fpt_pkg::CTRL_KEY) begin
         ctrl_pend <= w_data[3:0];
      end
   end

   // Sticky fault: a new fault beats a same-cycle clear
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         fault_raw <= 1'b0;
      end else if (op_reject || data_fault) begin
         fault_raw <= 1'b1; // [RULE_09] [RULE_10]
      end else if (write_go && aw_addr[11:2] == fpt_pkg::OFS_FAULT_CLR[11:2] &&
            w_strb[0] && w_data[fpt_pkg::FAULT_BIT]) begin
         fault_raw <= 1'b0;
      end
   end

   // Working policy: reset opens all, then reloads committed copy
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         read_enable <= fpt_pkg::RST_READ_ENABLE;
         prog_enable <= fpt_pkg::RST_PROG_ENABLE;
         load_pending <= 1'b1;
         debug_enable <= 1'b1;
      end else if (load_pending) begin
         load_pending <= 1'b0;
         read_enable <= read_commit; // [RULE_16]
         prog_enable <= prog_commit; // [RULE_16]
         debug_enable <= (read_commit[31:fpt_pkg::DBG_LSB] == fpt_pkg::DBG_OPEN); // [RULE_17] [RULE_18]
      end else if (write_go) begin
         // Cannot reopen anything committed closed
         if (aw_addr[11:2] == fpt_pkg::OFS_READ_ENABLE[11:2]) begin
            read_enable <= merge_bytes(read_enable, w_data, w_strb) & read_commit; // [RULE_15]
         end
         if (aw_addr[11:2] == fpt_pkg::OFS_PROG_ENABLE[11:2]) begin
            prog_enable <= merge_bytes(prog_enable, w_data, w_strb) & prog_commit; // [RULE_15]
         end
      end
   end

   // Committed copy stands for the nonvolatile store
   always_ff @(posedge I_CLOCK or negedge fac_n) begin
      if (!fac_n) begin
         read_commit <= fpt_pkg::RST_READ_ENABLE; // [RULE_14]
         prog_commit <= fpt_pkg::RST_PROG_ENABLE; // [RULE_14]
      end else if (op_done && ctrl_pend[fpt_pkg::CTRL_COMMIT_BIT]) begin
         if (flash_addr == fpt_pkg::SPECIAL_COMMIT_ADDR) begin
            read_commit <= read_commit & read_enable; // [RULE_22] [RULE_18]
         end else if (flash_addr[0]) begin
            prog_commit <= prog_commit & prog_enable; // [RULE_21]
         end else begin
            read_commit[fpt_pkg::READ_BLOCKS-1:0] <= read_commit[fpt_pkg::READ_BLOCKS-1:0] &
               read_enable[fpt_pkg::READ_BLOCKS-1:0]; // [RULE_21]
         end
      end
   end

   // Microsecond tick from reload count
   assign us_tick = (us_cnt == 8'h00); // [RULE_11]

   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         us_cnt <= 8'h00;
      end else if (us_tick) begin
         us_cnt <= usec_reload; // [RULE_23]
      end else begin
         us_cnt <= us_cnt - 8'h01;
      end
   end

   // Reject program or erase into a write-locked block
   assign op_reject = (state == fpt_pkg::ST_IDLE) &&
      (ctrl_pend[fpt_pkg::CTRL_WRITE_BIT] || ctrl_pend[fpt_pkg::CTRL_ERASE_BIT]) &&
      !prog_enable[block_of(tgt_word)]; // [RULE_05] [RULE_09]
   assign op_done = ((state == fpt_pkg::ST_WAIT) && us_tick && us_left == 16'h0001 &&
         (ctrl_pend[fpt_pkg::CTRL_WRITE_BIT] || ctrl_pend[fpt_pkg::CTRL_COMMIT_BIT])) ||
      ((state == fpt_pkg::ST_WIPE) && wipe_idx == wipe_end);

   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         state <= fpt_pkg::ST_IDLE;
         us_left <= 16'h0000;
         wipe_idx <= 14'h0000;
         wipe_end <= 14'h0000;
      end else begin
         case (state)
            fpt_pkg::ST_IDLE: begin
               if (O_FLASH_BUSY && !op_reject) begin
                  state <= fpt_pkg::ST_WAIT;
                  if (ctrl_pend[fpt_pkg::CTRL_WRITE_BIT]) begin
                     us_left <= 16'(PROG_US);
                  end else if (ctrl_pend[fpt_pkg::CTRL_ERASE_BIT]) begin
                     us_left <= 16'(ERASE_US);
                  end else if (ctrl_pend[fpt_pkg::CTRL_MERASE_BIT]) begin
                     us_left <= 16'(MERASE_US);
                  end else begin
                     us_left <= 16'(COMMIT_US);
                  end
                  if (ctrl_pend[fpt_pkg::CTRL_MERASE_BIT]) begin
                     wipe_idx <= 14'h0000;
                     wipe_end <= fpt_pkg::ARRAY_LAST_WORD;
                  end else begin
                     wipe_idx <= {tgt_word[13:fpt_pkg::PAGE_LSB], 8'h00}; // [RULE_01]
                     wipe_end <= {tgt_word[13:fpt_pkg::PAGE_LSB], 8'h00} |
                        fpt_pkg::PAGE_LAST_WORD;
                  end
               end
            end
            fpt_pkg::ST_WAIT: begin
               if (us_tick) begin
                  us_left <= us_left - 16'h0001; // [RULE_23]
                  if (us_left == 16'h0001) begin
                     state <= op_done ? fpt_pkg::ST_IDLE : fpt_pkg::ST_WIPE;
                  end
               end
            end
            fpt_pkg::ST_WIPE: begin
               wipe_idx <= wipe_idx + 14'h0001;
               if (wipe_idx == wipe_end) begin
                  state <= fpt_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= fpt_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Array: mass erase skips write-locked blocks
   always_ff @(posedge I_CLOCK) begin
      if (state == fpt_pkg::ST_WIPE && prog_enable[block_of(wipe_idx)]) begin
         flash_mem[wipe_idx] <= fpt_pkg::ERASED_WORD; // [RULE_01] [RULE_05]
      end else if (op_done && ctrl_pend[fpt_pkg::CTRL_WRITE_BIT]) begin
         flash_mem[tgt_word] <= flash_mem[tgt_word] & flash_data; // [RULE_02]
      end
   end

   // Read ports: fetch is never locked, data side honours read lock
   assign data_fault = I_DATA_VALID &&
      !readable(read_enable, I_DATA_ADDR[15:2]); // [RULE_06] [RULE_07]

   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         O_FETCH_DATA <= 32'h00000000;
         O_DATA_RDATA <= 32'h00000000;
      end else begin
         if (I_FETCH_VALID) begin
            O_FETCH_DATA <= flash_mem[I_FETCH_ADDR[15:2]]; // [RULE_06]
         end
         if (I_DATA_VALID) begin
            O_DATA_RDATA <= data_fault ? 32'h00000000 :
               flash_mem[I_DATA_ADDR[15:2]]; // [RULE_10] [RULE_08]
         end
      end
   end

   // Register read mux
   always_comb begin
      rd_mapped = 1'b1;
      case (I_AXI_ARADDR[11:2])
         fpt_pkg::OFS_FLASH_ADDR[11:2]: rd_mux = {16'h0000, flash_addr};
         fpt_pkg::OFS_FLASH_DATA[11:2]: rd_mux = flash_data;
         fpt_pkg::OFS_FLASH_CTRL[11:2]: rd_mux = {28'h0000000, ctrl_pend};
         fpt_pkg::OFS_FAULT_RAW[11:2]: rd_mux = {31'h00000000, fault_raw};
         fpt_pkg::OFS_IRQ_MASK[11:2]: rd_mux = {31'h00000000, fault_mask};
         fpt_pkg::OFS_FAULT_CLR[11:2]: rd_mux = {31'h00000000, O_FLASH_IRQ};
         fpt_pkg::OFS_READ_ENABLE[11:2]: rd_mux = read_enable; // [RULE_04]
         fpt_pkg::OFS_PROG_ENABLE[11:2]: rd_mux = prog_enable; // [RULE_04] [RULE_03]
         fpt_pkg::OFS_USEC_RELOAD[11:2]: rd_mux = {24'h000000, usec_reload};
         default: begin
            rd_mux = 32'h00000000;
            rd_mapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         O_AXI_RVALID <= 1'b0;
         O_AXI_RDATA <= 32'h00000000;
         O_AXI_RRESP <= fpt_pkg::RESP_OKAY;
      end else if (I_AXI_ARVALID && !O_AXI_RVALID) begin
         O_AXI_RVALID <= 1'b1;
         O_AXI_RDATA <= rd_mux;
         O_AXI_RRESP <= rd_mapped ? fpt_pkg::RESP_OKAY : fpt_pkg::RESP_SLVERR;
      end else if (O_AXI_RVALID && I_AXI_RREADY) begin
         O_AXI_RVALID <= 1'b0;
      end
   end

endmodule // fpt_flash_ctrl

// [bench/fpt_flash_ctrl_assertions.sv]
// Port-level checks for the flash protection controller
`timescale 1ns/1ps
module fpt_flash_ctrl_assertions (
   // Clock and reset
   input wire logic I_CLOCK,
   input wire logic I_RESETN,
   // Register bus
   input wire logic I_AXI_AWVALID,
   input wire logic O_AXI_AWREADY,
   input wire logic I_AXI_WVALID,
   input wire logic O_AXI_WREADY,
   input wire logic [1:0] O_AXI_BRESP,
   input wire logic O_AXI_BVALID,
   input wire logic I_AXI_BREADY,
   input wire logic I_AXI_ARVALID,
   input wire logic O_AXI_ARREADY,
   input wire logic [31:0] O_AXI_RDATA,
   input wire logic O_AXI_RVALID,
   input wire logic I_AXI_RREADY,
   // Core side and status
   input wire logic I_DATA_VALID,
   input wire logic O_DEBUG_PORT_ENABLE,
   input wire logic O_FLASH_BUSY,
   input wire logic O_FLASH_IRQ
);
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (!I_RESETN);
   // Debug gate settles a few edges after release, then must hold
   logic [2:0] since_rst;
   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) since_rst <= 3'h0;
      else if (since_rst != 3'h7) since_rst <= since_rst + 3'h1;
   end
   AST_DEBUG_LATCH: assert property (since_rst == 3'h7 |-> $stable(O_DEBUG_PORT_ENABLE))
      else $error("debug enable moved after reset");
   AST_IRQ_CAUSE: assert property ($rose(O_FLASH_IRQ) |->
      $past(I_DATA_VALID) || $past(O_FLASH_BUSY) || $rose(O_AXI_BVALID))
      else $error("interrupt rose without a cause");
   AST_BUSY_CAUSE: assert property ($rose(O_FLASH_BUSY) |-> $rose(O_AXI_BVALID))
      else $error("busy rose without a control write");
   AST_W_ANSWER: assert property (I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID &&
      O_AXI_WREADY && !O_AXI_BVALID |=> ##1 O_AXI_BVALID)
      else $error("write response late");
   AST_B_HOLD: assert property (O_AXI_BVALID && !I_AXI_BREADY |=>
      O_AXI_BVALID && $stable(O_AXI_BRESP))
      else $error("write response dropped");
   AST_AR_ANSWER: assert property (I_AXI_ARVALID && O_AXI_ARREADY |=> O_AXI_RVALID)
      else $error("read data late");
   AST_AR_BLOCK: assert property (O_AXI_RVALID |-> !O_AXI_ARREADY)
      else $error("read address taken while data waits");
   AST_R_HOLD: assert property (O_AXI_RVALID && !I_AXI_RREADY |=>
      O_AXI_RVALID && $stable(O_AXI_RDATA))
      else $error("read data dropped");
endmodule // fpt_flash_ctrl_assertions

bind fpt_flash_ctrl fpt_flash_ctrl_assertions u_chk (.I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN),
   .I_AXI_AWVALID(I_AXI_AWVALID), .O_AXI_AWREADY(O_AXI_AWREADY),
   .I_AXI_WVALID(I_AXI_WVALID), .O_AXI_WREADY(O_AXI_WREADY), .O_AXI_BRESP(O_AXI_BRESP),
   .O_AXI_BVALID(O_AXI_BVALID), .I_AXI_BREADY(I_AXI_BREADY), .I_AXI_ARVALID(I_AXI_ARVALID),
   .O_AXI_ARREADY(O_AXI_ARREADY), .O_AXI_RDATA(O_AXI_RDATA), .O_AXI_RVALID(O_AXI_RVALID),
   .I_AXI_RREADY(I_AXI_RREADY), .I_DATA_VALID(I_DATA_VALID),
   .O_DEBUG_PORT_ENABLE(O_DEBUG_PORT_ENABLE), .O_FLASH_BUSY(O_FLASH_BUSY),
   .O_FLASH_IRQ(O_FLASH_IRQ));

// [bench/fpt_core_model.sv]
// Core-side model: instruction fetch and data read buses
`timescale 1ns/1ps
module fpt_core_model (
   // Clock
   input wire logic i_clock,
   // Requests
   output logic o_fetch_valid,
   output logic [15:0] o_fetch_addr,
   output logic o_data_valid,
   output logic [15:0] o_data_addr,
   // Answers
   input wire logic [31:0] i_fetch_data,
   input wire logic [31:0] i_data_rdata
);
   initial begin
      o_fetch_valid = 1'b0;
      o_data_valid = 1'b0;
      o_fetch_addr = 16'h0;
      o_data_addr = 16'h0;
   end
   task automatic access(input logic fetch, input logic [15:0] a, output logic [31:0] d);
      @(posedge i_clock);
      if (fetch) o_fetch_valid <= 1'b1;
      else o_data_valid <= 1'b1;
      o_fetch_addr <= a;
      o_data_addr <= a;
      @(posedge i_clock);
      o_fetch_valid <= 1'b0;
      o_data_valid <= 1'b0;
      // Idle address is junk so a stale match cannot hide
      o_fetch_addr <= ~a;
      o_data_addr <= ~a;
      #1;
      d = fetch ? i_fetch_data : i_data_rdata;
   endtask
endmodule // fpt_core_model

// [bench/flash_protection_timing_test.sv]
// Register-level bench for the flash protection controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module flash_protection_timing_test;
   logic clk, rst_n, frst_n, awv, wv, br, arv, rr, awr, wr_r, bv, arr, rv;
   logic fv, dv, dbg, busy, irq;
   logic [11:0] awa, ara;
   logic [31:0] wd, rdata, fdata, ddata, d;
   logic [3:0] ws;
   logic [1:0] bresp, rresp, r;
   logic [15:0] fa, da;
   int err_total = 0;
   int num_checks = 0;
   int busy_n = 0;
   localparam logic [31:0] RD_OPEN = {fpt_pkg::DBG_OPEN, 30'h3fffffff};

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   fpt_flash_ctrl #(.PROG_US(2), .ERASE_US(2), .MERASE_US(2), .COMMIT_US(2)) dut (
      .I_CLOCK(clk), .I_RESETN(rst_n), .I_FACTORY_RESETN(frst_n),
      .I_AXI_AWADDR(awa), .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr), .I_AXI_WDATA(wd),
      .I_AXI_WSTRB(ws), .I_AXI_WVALID(wv), .O_AXI_WREADY(wr_r), .O_AXI_BRESP(bresp),
      .O_AXI_BVALID(bv), .I_AXI_BREADY(br), .I_AXI_ARADDR(ara), .I_AXI_ARVALID(arv),
      .O_AXI_ARREADY(arr), .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rv),
      .I_AXI_RREADY(rr), .I_FETCH_VALID(fv), .I_FETCH_ADDR(fa), .O_FETCH_DATA(fdata),
      .I_DATA_VALID(dv), .I_DATA_ADDR(da), .O_DATA_RDATA(ddata),
      .O_DEBUG_PORT_ENABLE(dbg), .O_FLASH_BUSY(busy), .O_FLASH_IRQ(irq));
   fpt_core_model core (.i_clock(clk), .o_fetch_valid(fv), .o_fetch_addr(fa),
      .o_data_valid(dv), .o_data_addr(da), .i_fetch_data(fdata), .i_data_rdata(ddata));

   // Counted mid-cycle so the busy level is settled
   always @(negedge clk) if (busy === 1'b1) busy_n++;

   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic hang(input int n);
      if (n >= 500) begin
         err_total++;
         $display("[FAIL] wait exp done got timeout");
         end_of_test();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      logic ha, hw, hb;
      @(posedge clk);
      awa <= a; awv <= 1'b1; wd <= v; ws <= 4'hf; wv <= 1'b1; br <= 1'b1;
      for (n = 0; n < 500; n++) begin
         #1;
         ha = awv & awr; hw = wv & wr_r; hb = bv; rs = bresp;
         @(posedge clk);
         if (ha) awv <= 1'b0;
         if (hw) wv <= 1'b0;
         if (hb) begin
            br <= 1'b0;
            break;
         end
      end
      hang(n);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      logic ha, hb;
      @(posedge clk);
      ara <= a; arv <= 1'b1; rr <= 1'b1;
      for (n = 0; n < 500; n++) begin
         #1;
         ha = arv & arr; hb = rv; v = rdata; rs = rresp;
         @(posedge clk);
         if (ha) arv <= 1'b0;
         if (hb) begin
            rr <= 1'b0;
            break;
         end
      end
      hang(n);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string n);
      rd(a, d, r);
      `CHK(n, e, d)
   endtask
   task automatic fchk(input logic f, input logic [15:0] a, input logic [31:0] e, input string n);
      core.access(f, a, d);
      `CHK(n, e, d)
   endtask
   // Data, address, keyed control word, then poll until the start bits drop
   task automatic op(input logic [15:0] a, input logic [31:0] v, input logic [3:0] c);
      int n;
      wr(12'h004, v, r);
      wr(12'h000, {16'h0, a}, r);
      busy_n = 0;
      wr(12'h008, {fpt_pkg::CTRL_KEY, 12'h0, c}, r);
      for (n = 0; n < 500; n++) begin
         rd(12'h008, d, r);
         if (d[3:0] === 4'h0) break;
      end
      hang(n);
   endtask
   task automatic reset_dut;
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      frst_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask

   initial begin
      frst_n = 1'b0; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0;
      rr = 1'b0; awa = 12'h0; ara = 12'h0; wd = 32'h0; ws = 4'h0;
      reset_dut();
      rchk(12'h130, RD_OPEN, "read enable");
      rchk(12'h134, 32'hffffffff, "prog enable");
      rchk(12'h140, {24'h0, fpt_pkg::RST_USEC_RELOAD}, "usec reload");
      `CHK("debug enable", 1'b1, dbg)
      rd(12'h020, d, r);
      `CHK("unmapped resp", fpt_pkg::RESP_SLVERR, r)
      wr(12'h020, 32'h0, r);
      `CHK("unmapped wr resp", fpt_pkg::RESP_SLVERR, r)
      $display("done: reset values");
      op(16'h0400, 32'h0, 4'h2);
      op(16'h0400, 32'h5a5a5a5a, 4'h1);
      `CHK("slow prog time", 1'b1, busy_n inside {[52:101]})
      wr(12'h140, 32'h1, r);
      op(16'h0000, 32'h0, 4'h2);
      fchk(1'b1, 16'h03fc, 32'hffffffff, "erased word");
      fchk(1'b1, 16'h0400, 32'h5a5a5a5a, "next page kept");
      op(16'h0000, 32'h1234abcd, 4'h1);
      `CHK("fast prog time", 1'b1, busy_n inside {[4:5]})
      op(16'h0000, 32'hffff00ff, 4'h1);
      fchk(1'b0, 16'h0000, 32'h123400cd, "open data read");
      $display("done: timing and array");
      wr(12'h130, {fpt_pkg::DBG_OPEN, 30'h3ffffffe}, r);
      fchk(1'b0, 16'h0000, 32'h0, "locked data");
      fchk(1'b1, 16'h0000, 32'h123400cd, "locked fetch");
      `CHK("irq masked", 1'b0, irq)
      rchk(12'h00c, 32'h1, "raw fault");
      wr(12'h010, 32'h1, r);
      `CHK("irq unmasked", 1'b1, irq)
      wr(12'h014, 32'h1, r);
      `CHK("irq cleared", 1'b0, irq)
      op(16'h0000, 32'hff0000ff, 4'h1);
      fchk(1'b1, 16'h0000, 32'h120000cd, "write under read lock");
      $display("done: read lock");
      wr(12'h134, 32'hfffffffe, r);
      op(16'h0000, 32'h0, 4'h1);
      op(16'h0000, 32'h0, 4'h2);
      fchk(1'b1, 16'h0000, 32'h120000cd, "write locked word");
      `CHK("irq on refusal", 1'b1, irq)
      wr(12'h014, 32'h1, r);
      $display("done: program lock");
      op(16'h0001, 32'h0, 4'h8);
      reset_dut();
      rchk(12'h134, 32'hfffffffe, "committed prog");
      rchk(12'h130, RD_OPEN, "reverted read");
      wr(12'h134, 32'hffffffff, r);
      rchk(12'h134, 32'hfffffffe, "no undo");
      $display("done: commit");
      wr(12'h130, 32'h3ffffffe, r);
      `CHK("debug before power-up", 1'b1, dbg)
      op(16'h0900, 32'h0, 4'h8);
      reset_dut();
      `CHK("debug after power-up", 1'b0, dbg)
      rchk(12'h130, 32'h3ffffffe, "special commit");
      wr(12'h130, 32'hffffffff, r);
      rchk(12'h130, 32'h3ffffffe, "debug gate stays");
      $display("done: debug gate");
      end_of_test();
   end
endmodule // flash_protection_timing_test
